// ---- switch_global_control_pkg.sv ----
// constants for the switch identity and first global control registers
package switch_global_control_pkg;
  // register byte offsets on the host port
  localparam logic [11:0] CHIP_IDENTITY_AND_START_OFS = 12'h000;
  localparam logic [11:0] SWITCH_GLOBAL_CONTROL_FIRST_OFS = 12'h002;
  // identity register fields
  localparam int ID_FAMILY_LSB = 8;
  localparam int ID_CHIP_LSB = 4;
  localparam int ID_REV_LSB = 1;
  localparam int ID_START_BIT = 0;
  localparam logic START_RESET = 1'h1;
  // first global control register fields
  localparam int GC_PASS_ALL = 15;
  localparam int GC_RX_2000 = 14;
  localparam int GC_TX_FLOW = 13;
  localparam int GC_RX_FLOW = 12;
  localparam int GC_LEN_CHECK = 11;
  localparam int GC_AGING = 10;
  localparam int GC_FAST_AGE = 9;
  localparam int GC_AGGR_BACKOFF = 8;
  localparam int GC_RES_HI_LSB = 6;
  localparam int GC_INGRESS_FLOW = 5;
  localparam int GC_RX_2K = 4;
  localparam int GC_PASS_FLOW_PKT = 3;
  localparam int GC_RES_LO_LSB = 1;
  localparam int GC_LINK_CHANGE_AGE = 0;
  localparam logic [15:0] GC_RESET = 16'h3450;
  // frame length limits in bytes
  localparam logic [11:0] LEN_2000 = 12'h7D0;
  localparam logic [11:0] LEN_HUGE = 12'h77C;
  localparam logic [11:0] LEN_TAGGED = 12'h5F2;
  localparam logic [11:0] LEN_UNTAGGED = 12'h5EE;
  localparam logic [11:0] LEN_DEFAULT = 12'h600;
  localparam logic [15:0] LEN_FIELD_LIMIT = 16'h05DC;
  // aging timing
  localparam longint CLK_FREQ_HZ = 25000000;
  localparam longint US_PER_S = 1000000;
  localparam longint AGE_NORMAL_S = 300;
  localparam longint AGE_SPREAD_S = 75;
  localparam longint FAST_AGE_US = 800;
  localparam logic [4:0] CYCLES_PER_US = 5'(CLK_FREQ_HZ / US_PER_S);
  localparam longint AGE_NORMAL_US = AGE_NORMAL_S * US_PER_S;
  // host access states
  typedef enum logic [1:0] {HOST_IDLE, HOST_ANSWER} host_state_t;
endpackage

// ---- switch_global_control_regs.sv ----
// identity and first global control registers of the switch
`timescale 1ns/100ps

// Operation
// - identity codes read only, writes ignored
// - bit 0 start switch, default one
// - pass bad frames only in sniffer mode
// - bit 14 accepts frames up to 2000
// - bit 13 clear stops pause generation
// - bit 12 clear ignores received pause
// - bit 11 checks length field below 1500
// - bit 10 enables address aging
// - bit 9 selects 800 us aging
// - bit 8 selects aggressive back-off
// - bit 5 pause instead of drop
// - bit 4 accepts 2K, overrides second register; code limits it to 2000 bytes, as for bit 14
// - bit 3 forwards pause frames
// - link loss causes one fast age cycle
// - unplugged port flushes all addresses
// - reserved fields readable, writable, defaults kept
module switch_global_control_regs
  import switch_global_control_pkg::*;
#(
  parameter int NUM_PORTS = 2,
  parameter logic [7:0] FAMILY_CODE = 8'h5A, // arbitrary value
  parameter logic [3:0] CHIP_CODE = 4'h6, // arbitrary value
  parameter logic [2:0] REV_CODE = 3'h2, // arbitrary value
  parameter int CYCLE_US = int'(CYCLES_PER_US),
  parameter longint NORMAL_AGE_US = AGE_NORMAL_US,
  parameter longint FAST_PERIOD_US = FAST_AGE_US
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] hostAddr,
  input wire logic hostRead,
  input wire logic hostWrite,
  input wire logic [1:0] hostByteEn,
  input wire logic [15:0] hostWdata,
  output logic [15:0] hostRdata,
  output logic hostAck,
  input wire logic [NUM_PORTS-1:0] linkUp,
  input wire logic sniffMode,
  input wire logic secondHugeEnable,
  input wire logic secondLegalCheck,
  input wire logic frameValid,
  input wire logic [11:0] frameLength,
  input wire logic [15:0] lengthTypeField,
  input wire logic [11:0] payloadLength,
  input wire logic frameTagged,
  input wire logic frameBad,
  input wire logic framePause,
  input wire logic rateExceeded,
  input wire logic pauseRequest,
  output logic frameDone,
  output logic frameDrop,
  output logic pauseSend,
  output logic pauseApply,
  output logic switchStart,
  output logic aggressiveBackoff,
  output logic ageTick,
  output logic ageFlushAll
);
  logic [1:0] rstPipe;
  logic rstN;
  host_state_t hostState;
  logic startBit;
  logic [15:0] globalCtrl;
  logic [NUM_PORTS-1:0] linkMeta;
  logic [NUM_PORTS-1:0] linkSync;
  logic [NUM_PORTS-1:0] linkPrev;
  logic linkFall;
  logic linkChangePending;
  logic [4:0] usCount;
  logic usTick;
  logic [31:0] ageCount;
  logic [31:0] agePeriod;
  logic [11:0] maxLength;
  logic tooLong;
  logic lengthMismatch;
  logic badDrop;
  logic next_drop;
  logic [15:0] idWord;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rstPipe <= 2'h0;
    else
      rstPipe <= {rstPipe[0], 1'h1};
  end
  assign rstN = rstPipe[1];

  // identity word: fixed codes plus the start bit
  assign idWord = {FAMILY_CODE, CHIP_CODE, REV_CODE, startBit};

  // host port: one answer cycle per request, unmapped reads return zero
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      hostState <= HOST_IDLE;
      hostAck <= 1'h0;
      hostRdata <= 16'h0000;
    end
    else
    begin
      hostAck <= 1'h0;
      case (hostState)
        HOST_IDLE:
        begin
          if (hostRead || hostWrite)
          begin
            hostState <= HOST_ANSWER;
            hostAck <= 1'h1;
            hostRdata <= 16'h0000;
            if (hostRead && hostAddr == CHIP_IDENTITY_AND_START_OFS)
              hostRdata <= idWord;
            else if (hostRead && hostAddr == SWITCH_GLOBAL_CONTROL_FIRST_OFS)
              hostRdata <= globalCtrl;
          end
        end
        HOST_ANSWER:
          hostState <= HOST_IDLE;
        default:
          hostState <= HOST_IDLE;
      endcase
    end
  end

  // register writes; accepted whatever the start bit holds
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      startBit <= START_RESET;
      globalCtrl <= GC_RESET;
    end
    else if (hostWrite && hostState == HOST_IDLE)
    begin
      if (hostAddr == CHIP_IDENTITY_AND_START_OFS && hostByteEn[0])
        startBit <= hostWdata[ID_START_BIT];
      if (hostAddr == SWITCH_GLOBAL_CONTROL_FIRST_OFS)
      begin
        if (hostByteEn[0])
          globalCtrl[7:0] <= hostWdata[7:0];
        if (hostByteEn[1])
          globalCtrl[15:8] <= hostWdata[15:8];
      end
    end
  end

  assign switchStart = startBit;
  assign aggressiveBackoff = globalCtrl[GC_AGGR_BACKOFF];

  // link status from the ports is asynchronous
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      linkMeta <= '0;
      linkSync <= '0;
      linkPrev <= '0;
    end
    else
    begin
      linkMeta <= linkUp;
      linkSync <= linkMeta;
      linkPrev <= linkSync;
    end
  end
  assign linkFall = |(linkPrev & ~linkSync);

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      ageFlushAll <= 1'h0;
    else
      ageFlushAll <= linkFall;
  end

  // microsecond prescaler for the aging timer
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      usCount <= 5'h00;
    else if (usTick)
      usCount <= 5'h00;
    else
      usCount <= usCount + 5'h01;
  end
  assign usTick = (usCount == 5'(CYCLE_US - 1));

  // one fast cycle after link loss; a new loss wins over the clear
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      linkChangePending <= 1'h0;
    else if (linkFall && globalCtrl[GC_LINK_CHANGE_AGE])
      linkChangePending <= 1'h1;
    else if (ageTick)
      linkChangePending <= 1'h0;
  end

  assign agePeriod = (globalCtrl[GC_FAST_AGE] || linkChangePending)
    ? 32'(FAST_PERIOD_US) : 32'(NORMAL_AGE_US);

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ageCount <= 32'h00000000;
      ageTick <= 1'h0;
    end
    else
    begin
      ageTick <= 1'h0;
      if (!globalCtrl[GC_AGING])
        ageCount <= 32'h00000000;
      else if (linkFall && globalCtrl[GC_LINK_CHANGE_AGE])
        ageCount <= 32'h00000000;
      else if (usTick)
      begin
        if (ageCount >= agePeriod - 32'h00000001)
        begin
          ageCount <= 32'h00000000;
          ageTick <= 1'h1;
        end
        else
          ageCount <= ageCount + 32'h00000001;
      end
    end
  end

  // receive length limit
  always_comb
  begin
    if (globalCtrl[GC_RX_2K] || globalCtrl[GC_RX_2000])
      maxLength = LEN_2000;
    else if (secondHugeEnable)
      maxLength = LEN_HUGE;
    else if (secondLegalCheck)
      maxLength = frameTagged ? LEN_TAGGED : LEN_UNTAGGED;
    else
      maxLength = LEN_DEFAULT;
  end
  assign tooLong = frameLength > maxLength;
  assign lengthMismatch = globalCtrl[GC_LEN_CHECK]
    && lengthTypeField < LEN_FIELD_LIMIT
    && lengthTypeField != {4'h0, payloadLength};
  assign badDrop = frameBad
    && !(globalCtrl[GC_PASS_ALL] && sniffMode);

  always_comb
  begin
    next_drop = !startBit || badDrop || tooLong || lengthMismatch;
    if (framePause && !globalCtrl[GC_PASS_FLOW_PKT])
      next_drop = 1'h1;
    if (rateExceeded && !globalCtrl[GC_INGRESS_FLOW])
      next_drop = 1'h1;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      frameDone <= 1'h0;
      frameDrop <= 1'h0;
      pauseApply <= 1'h0;
    end
    else
    begin
      frameDone <= frameValid;
      frameDrop <= frameValid && next_drop;
      pauseApply <= frameValid && framePause && startBit
        && globalCtrl[GC_RX_FLOW];
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      pauseSend <= 1'h0;
    else
      pauseSend <= globalCtrl[GC_TX_FLOW] && startBit
        && (pauseRequest || (frameValid && rateExceeded
        && globalCtrl[GC_INGRESS_FLOW]));
  end

  chk_id_fixed: assert property (@(posedge clk)
    disable iff (!rstN) hostAck && $past(hostRead)
    && $past(hostAddr) == 12'h000
    |-> hostRdata[15:1] == {FAMILY_CODE, CHIP_CODE, REV_CODE})
    else $error("identity code wrong");
  chk_start_write: assert property (@(posedge clk)
    disable iff (!rstN) hostWrite && hostState == HOST_IDLE
    && hostAddr == 12'h000 && hostByteEn[0]
    |=> switchStart == $past(hostWdata[0]))
    else $error("start bit not written");
  chk_bad_pass: assert property (@(posedge clk)
    disable iff (!rstN) frameValid && frameBad
    && !(globalCtrl[15] && sniffMode) |=> frameDrop)
    else $error("bad frame passed");
  chk_len_2000: assert property (@(posedge clk)
    disable iff (!rstN) frameValid && globalCtrl[14]
    && frameLength > 12'h7D0 |=> frameDrop)
    else $error("over 2000 bytes accepted");
  chk_tx_pause: assert property (@(posedge clk)
    disable iff (!rstN) !globalCtrl[13] |=> !pauseSend)
    else $error("pause sent while disabled");
  chk_rx_pause: assert property (@(posedge clk)
    disable iff (!rstN) !globalCtrl[12] |=> !pauseApply)
    else $error("received pause obeyed");
  chk_len_field: assert property (@(posedge clk)
    disable iff (!rstN) frameValid && globalCtrl[11]
    && lengthTypeField < 16'h05DC
    && lengthTypeField != {4'h0, payloadLength} |=> frameDrop)
    else $error("length mismatch kept");
  chk_aging_off: assert property (@(posedge clk)
    disable iff (!rstN) !globalCtrl[10] |=> !ageTick)
    else $error("aging while disabled");
  chk_ingress_drop: assert property (@(posedge clk)
    disable iff (!rstN) frameValid && rateExceeded && !globalCtrl[5]
    |=> frameDrop)
    else $error("over-limit frame kept");
  chk_flush_link: assert property (@(posedge clk)
    disable iff (!rstN) linkFall |=> ageFlushAll)
    else $error("no flush on unplug");
  chk_pause_filter: assert property (@(posedge clk)
    disable iff (!rstN) frameValid && framePause && !globalCtrl[3]
    |=> frameDrop)
    else $error("pause frame forwarded");
  chk_link_pending: assert property (@(posedge clk)
    disable iff (!rstN) linkFall && globalCtrl[0] |=> linkChangePending)
    else $error("link change age missed");
  chk_fast_bound: assert property (@(posedge clk)
    disable iff (!rstN) globalCtrl[9] && ageCount < 32'(FAST_PERIOD_US)
    |=> ageCount < 32'(FAST_PERIOD_US))
    else $error("fast age period exceeded");
  chk_len_2k: assert property (@(posedge clk)
    disable iff (!rstN) frameValid && !globalCtrl[4] && !globalCtrl[14]
    && frameLength > 12'h7D0 |=> frameDrop)
    else $error("over 2000 bytes kept");
  chk_ctrl_write: assert property (@(posedge clk)
    disable iff (!rstN) hostWrite && hostState == HOST_IDLE
    && hostAddr == 12'h002 && hostByteEn == 2'h3
    |=> globalCtrl == $past(hostWdata))
    else $error("control word not stored");
  chk_reset_default: assert property (@(posedge clk)
    $rose(rstN) |-> globalCtrl == 16'h3450 && switchStart)
    else $error("defaults not restored");
endmodule // switch_global_control_regs

// ---- host_software_model.sv ----
// host processor model for the register port
`timescale 1ns/100ps
module host_software_model (
  input wire logic clk,
  input wire logic [15:0] hostRdata,
  input wire logic hostAck,
  output logic [11:0] hostAddr,
  output logic hostRead,
  output logic hostWrite,
  output logic [1:0] hostByteEn,
  output logic [15:0] hostWdata
);
  initial
  begin
    hostAddr = 12'h000;
    hostRead = 1'b0;
    hostWrite = 1'b0;
    hostByteEn = 2'h3;
    hostWdata = 16'h0000;
  end
  task automatic access(input logic wr, input logic [11:0] addr,
    input logic [15:0] wdata, output logic [15:0] rdata, output logic ok);
    ok = 1'b0;
    rdata = 16'h0000;
    @(posedge clk);
    hostAddr <= addr;
    hostWrite <= wr;
    hostRead <= !wr;
    hostWdata <= wdata;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge clk);
      if (hostAck === 1'b1)
      begin
        ok = 1'b1;
        rdata = hostRdata;
      end
    end
    // request held until the answer edge, then released
    hostRead <= 1'b0;
    hostWrite <= 1'b0;
    hostWdata <= ~wdata;
  endtask
  // read, merge, write back keeps the reserved fields
  task automatic modify(input logic [11:0] addr, input logic [15:0] setMask,
    input logic [15:0] clrMask, output logic ok);
    logic [15:0] cur;
    access(1'b0, addr, 16'h0000, cur, ok);
    if (ok)
      access(1'b1, addr, (cur & ~clrMask) | setMask, cur, ok);
  endtask
endmodule // host_software_model

// ---- tb_switch_global_control_regs.sv ----
// self-checking bench for the identity and first control registers
`timescale 1ns/100ps
module tb_switch_global_control_regs;
  import switch_global_control_pkg::*;
  localparam logic [15:0] ID_VAL = {8'h3C, 4'h9, 3'h5, 1'b1}; // arbitrary
  logic clk = 1'b0, reset_n = 1'b0, hostRead, hostWrite, hostAck;
  logic [11:0] hostAddr, frameLength = 12'h040;
  logic [1:0] hostByteEn, linkUp = 2'h3;
  logic [15:0] hostWdata, hostRdata, rd;
  logic sniffMode = 0, frameValid = 0, frameBad = 0, rateExceeded = 0;
  logic pauseRequest = 0, frameDone, frameDrop, pauseSend, pauseApply;
  logic secondHugeEnable = 0, secondLegalCheck = 0, frameTagged = 0;
  logic framePause = 0, expApply = 0;
  logic [15:0] lengthTypeField = 16'h0800;
  logic [11:0] payloadLength = 12'h040;
  logic switchStart, aggressiveBackoff, ageTick, ageFlushAll, ok;
  int nErrors = 0, samplesChecked = 0, cnt;
  switch_global_control_regs #(.FAMILY_CODE(8'h3C), .CHIP_CODE(4'h9),
    .REV_CODE(3'h5), .NORMAL_AGE_US(40), .FAST_PERIOD_US(4))
  i_switch_global_control_regs (.clk(clk), .reset_n(reset_n),
    .hostAddr(hostAddr), .hostRead(hostRead), .hostWrite(hostWrite),
    .hostByteEn(hostByteEn), .hostWdata(hostWdata), .hostRdata(hostRdata),
    .hostAck(hostAck), .linkUp(linkUp), .sniffMode(sniffMode),
    .secondHugeEnable(secondHugeEnable), .secondLegalCheck(secondLegalCheck),
    .frameValid(frameValid), .frameLength(frameLength),
    .lengthTypeField(lengthTypeField), .payloadLength(payloadLength),
    .frameTagged(frameTagged),
    .frameBad(frameBad), .framePause(framePause), .rateExceeded(rateExceeded),
    .pauseRequest(pauseRequest), .frameDone(frameDone), .frameDrop(frameDrop),
    .pauseSend(pauseSend), .pauseApply(pauseApply), .switchStart(switchStart),
    .aggressiveBackoff(aggressiveBackoff), .ageTick(ageTick),
    .ageFlushAll(ageFlushAll));
  host_software_model i_host_software_model (.clk(clk), .hostRdata(hostRdata),
    .hostAck(hostAck), .hostAddr(hostAddr), .hostRead(hostRead),
    .hostWrite(hostWrite), .hostByteEn(hostByteEn), .hostWdata(hostWdata));
  initial
  begin
    forever #20 clk = ~clk;
  end
  task automatic conclude();
    if (nErrors == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic guard();
    if (ok !== 1'b1)
    begin
      nErrors++;
      $display("mismatch hostAck expected 1 seen 0");
      conclude();
    end
  endtask
  task automatic wr(logic [11:0] a, logic [15:0] d);
    i_host_software_model.access(1'b1, a, d, rd, ok);
    guard();
  endtask
  task automatic rdc(string what, logic [11:0] a, logic [15:0] exp);
    i_host_software_model.access(1'b0, a, 16'h0000, rd, ok);
    guard();
    check(what, rd, exp);
  endtask
  task automatic mod(logic [15:0] s, logic [15:0] c);
    i_host_software_model.modify(SWITCH_GLOBAL_CONTROL_FIRST_OFS, s, c, ok);
    guard();
  endtask
  task automatic frame(logic [11:0] len, logic bad, logic rate,
    logic expDrop, logic expPause);
    @(posedge clk);
    frameValid <= 1'b1;
    frameLength <= len;
    frameBad <= bad;
    rateExceeded <= rate;
    @(posedge clk);
    frameValid <= 1'b0;
    frameLength <= ~len;
    @(posedge clk);
    check("frameDone", 16'(frameDone), 16'h1);
    check("frameDrop", 16'(frameDrop), 16'(expDrop));
    check("pauseSend", 16'(pauseSend), 16'(expPause));
    check("pauseApply", 16'(pauseApply), 16'(expApply));
  endtask
  task automatic ticks(int n);
    cnt = 0;
    repeat (n)
    begin
      @(posedge clk);
      cnt += int'(ageTick === 1'b1);
    end
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc("identity", CHIP_IDENTITY_AND_START_OFS, ID_VAL);
    rdc("control", SWITCH_GLOBAL_CONTROL_FIRST_OFS, 16'h3450);
    check("switchStart", 16'(switchStart), 16'h1);
    wr(CHIP_IDENTITY_AND_START_OFS, 16'h0000);
    rdc("identity", CHIP_IDENTITY_AND_START_OFS, ID_VAL & 16'hFFFE);
    frame(12'h040, 1'b0, 1'b0, 1'b1, 1'b0);
    rdc("control", SWITCH_GLOBAL_CONTROL_FIRST_OFS, 16'h3450);
    wr(CHIP_IDENTITY_AND_START_OFS, 16'hFFFF);
    rdc("identity", CHIP_IDENTITY_AND_START_OFS, ID_VAL);
    wr(12'h010, 16'hFFFF);
    rdc("unmapped", 12'h010, 16'h0000);
    frame(12'h7D0, 1'b0, 1'b0, 1'b0, 1'b0);
    frame(12'h7D1, 1'b0, 1'b0, 1'b1, 1'b0);
    frame(12'h040, 1'b1, 1'b0, 1'b1, 1'b0);
    frame(12'h040, 1'b0, 1'b1, 1'b1, 1'b0);
    mod(16'h8126, 16'h0010);
    rdc("control", SWITCH_GLOBAL_CONTROL_FIRST_OFS, 16'hB566);
    check("aggressiveBackoff", 16'(aggressiveBackoff), 16'h1);
    frame(12'h7D1, 1'b0, 1'b0, 1'b1, 1'b0);
    frame(12'h040, 1'b1, 1'b0, 1'b1, 1'b0);
    sniffMode <= 1'b1;
    frame(12'h040, 1'b1, 1'b0, 1'b0, 1'b0);
    frame(12'h040, 1'b0, 1'b1, 1'b0, 1'b1);
    mod(16'h4000, 16'h2000);
    frame(12'h7D0, 1'b0, 1'b0, 1'b0, 1'b0);
    frame(12'h040, 1'b0, 1'b1, 1'b0, 1'b0);
    framePause <= 1'b1;
    expApply <= 1'b1;
    frame(12'h040, 1'b0, 1'b0, 1'b1, 1'b0);
    mod(16'h0008, 16'h1000);
    expApply <= 1'b0;
    frame(12'h040, 1'b0, 1'b0, 1'b0, 1'b0);
    framePause <= 1'b0;
    mod(16'h0800, 16'h0000);
    lengthTypeField <= 16'h0100;
    frame(12'h040, 1'b0, 1'b0, 1'b1, 1'b0);
    payloadLength <= 12'h100;
    frame(12'h040, 1'b0, 1'b0, 1'b0, 1'b0);
    secondHugeEnable <= 1'b1;
    secondLegalCheck <= 1'b1;
    mod(16'h0010, 16'h4000);
    frame(12'h7D0, 1'b0, 1'b0, 1'b0, 1'b0);
    mod(16'h0000, 16'h0010);
    frame(12'h77D, 1'b0, 1'b0, 1'b1, 1'b0);
    secondHugeEnable <= 1'b0;
    frameTagged <= 1'b1;
    frame(12'h5F3, 1'b0, 1'b0, 1'b1, 1'b0);
    frame(12'h5F2, 1'b0, 1'b0, 1'b0, 1'b0);
    secondLegalCheck <= 1'b0;
    frameTagged <= 1'b0;
    ticks(2500);
    check("normal ticks", 16'(cnt inside {[2:3]}), 16'h1);
    mod(16'h0200, 16'h0000);
    ticks(2500);
    check("fast ticks", 16'(cnt > 20), 16'h1);
    mod(16'h0000, 16'h0600);
    ticks(2500);
    check("aging off", 16'(cnt), 16'h0);
    @(posedge clk);
    linkUp <= 2'h1;
    cnt = 0;
    repeat (8)
    begin
      @(posedge clk);
      cnt += int'(ageFlushAll === 1'b1);
    end
    check("ageFlushAll", 16'(cnt), 16'h1);
    mod(16'h0401, 16'h0000);
    linkUp <= 2'h3;
    repeat (4) @(posedge clk);
    linkUp <= 2'h1;
    ticks(200);
    check("link change ticks", 16'(cnt), 16'h1);
    wr(CHIP_IDENTITY_AND_START_OFS, 16'h0000);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc("control", SWITCH_GLOBAL_CONTROL_FIRST_OFS, 16'h3450);
    rdc("identity", CHIP_IDENTITY_AND_START_OFS, ID_VAL);
    conclude();
  end
endmodule // tb_switch_global_control_regs
